/* File: logic/mport_defs.svh */
// Behaviour
// - Data moves over a 32-bit bidirectional external data bus.
// - The data bus also runs 8 or 16 bits wide.
// - Two SDRAM banks, each with its own active-low select.
// - Active-low row strobe marks the row address phase.
// - Active-low column strobe marks the column address phase.
// - Active-low write enable tells SDRAM writes from reads.
// - A high byte mask during a write blocks that lane's store.
// - Byte masks 0 to 3 cover data bits 7:0 up to 31:24.
// - Three I/O banks, each with its own active-low select.
// - Each I/O bank decodes at most 16 KB of address.
// - An I/O access asserts only the addressed bank's select.
// - SDRAM address on bits 12:0, bank address on bits 21:20.
// - SDRAM column address width is 8 to 11 bits.
// - Low external wait stretches an I/O access until released.
`ifndef MPORT_DEFS_SVH
`define MPORT_DEFS_SVH

`define MP_CLK_MHZ      250
`define MP_DATA_W       32
`define MP_LANES        4
`define MP_PIN_ADDR_W   22
`define MP_REQ_ADDR_W   24
`define MP_SDR_ROW_W    13
`define MP_SDR_BA_LSB   20
`define MP_SDR_AP_BIT   10
`define MP_IO_ADDR_W    14
`define MP_IO_BANKS     3
`define MP_SDR_BANKS    2
`define MP_COL_MIN      8
`define MP_COL_MAX      11
`define MP_TRCD_NS      20
`define MP_TRP_NS       20
`define MP_TWR_NS       15
`define MP_NS2CYC(ns)   (((ns) * `MP_CLK_MHZ + 999) / 1000)
`define MP_TRCD_CYC     `MP_NS2CYC(`MP_TRCD_NS)
`define MP_TRP_CYC      `MP_NS2CYC(`MP_TRP_NS)
`define MP_TWR_CYC      `MP_NS2CYC(`MP_TWR_NS)
`define MP_CAS_LAT      2

`endif

/* File: logic/mport_pkg.sv */
`default_nettype none
package mport_pkg;

  // Bus width selection
  typedef enum logic [1:0] {
    MP_W8,
    MP_W16,
    MP_W32
  } mport_width_t;

  // One access request from the system side
  typedef struct packed {
    logic        write;
    logic        io;
    logic [1:0]  bank;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } mport_req_t;

  // SDRAM command pins, all active low except mask
  typedef struct packed {
    logic [1:0] cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [3:0] dqm;
  } mport_sdr_pins_t;

endpackage : mport_pkg
`default_nettype wire

/* File: logic/mport_mem_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mport_defs.svh"

module mport_mem_port
  import mport_pkg::*;
#(
  parameter int CAS_LAT = `MP_CAS_LAT,
  parameter int TRCD    = `MP_TRCD_CYC,
  parameter int TRP     = `MP_TRP_CYC,
  parameter int TWR     = `MP_TWR_CYC
)
(
  input  wire logic               clock,               // System clock
  input  wire logic               rst_b,               // Async reset, low
  input  wire mport_width_t       bus_width,           // Data bus width
  input  wire logic [1:0]         col_bits_sel,        // 0..3 = 8..11 cols
  input  wire logic [7:0]         io_wait_cfg,         // I/O extra cycles
  input  wire logic               req_valid,           // Request offered
  input  wire mport_req_t         req,                 // Request body
  output logic                    req_ready,           // Idle, can accept
  output logic                    rsp_valid,           // Access done pulse
  output logic [31:0]             rsp_rdata,           // Read data
  output logic [21:0]             ext_addr,            // Address pins
  input  wire logic [31:0]        ext_data_lane_in,    // Data pins in
  output logic [31:0]             ext_data_lane_out,   // Data pins out
  output logic [3:0]              ext_data_lane_oe,    // Per-lane drive
  output logic [1:0]              sdram_bank_select_n, // SDRAM selects
  output logic                    sdram_row_strobe_n,  // Row strobe
  output logic                    sdram_col_strobe_n,  // Column strobe
  output logic                    sdram_write_en_n,    // Write enable
  output logic [3:0]              sdram_byte_mask,     // Lane masks
  output logic [2:0]              io_bank_select_n,    // I/O selects
  input  wire logic               ext_wait_n           // Wait, low
);

  // Settings the logic cannot serve
  if (CAS_LAT < 1 || CAS_LAT > 3)
    $error("CAS_LAT must be 1 to 3");
  if (TRCD < 1 || TRP < 1 || TWR < 1 || TRCD > 255 || TRP > 255 || TWR > 255)
    $error("timing counts must be 1 to 255");

  // No refresh or power-up sequence; the system side owns them
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RCD,
    ST_CAS,
    ST_RP,
    ST_IO
  } mport_state_t;

  // Idle pin set: no command, no bank, every lane masked
  localparam mport_sdr_pins_t SDR_IDLE = '{
    cs_n: 2'h3, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, dqm: 4'hF};

  // Registered state; every pin output is one of these
  mport_state_t    state_reg, state_next;
  logic [7:0]      cnt_reg, cnt_next;
  mport_req_t      cur_reg, cur_next;
  mport_sdr_pins_t sdr_reg, sdr_next;
  logic [2:0]      ios_reg, ios_next;
  logic [21:0]     addr_reg, addr_next;
  logic [31:0]     dout_reg, dout_next;
  logic [3:0]      oe_reg, oe_next;
  logic            rdy_reg, rdy_next;
  logic            rv_reg, rv_next;
  logic [31:0]     rd_reg, rd_next;

  // Lanes live for the chosen width, low lanes first
  // Narrow widths leave the upper lanes undriven and masked
  logic [3:0] lane_en;
  always_comb
  begin
    case (bus_width)
      MP_W8:   lane_en = 4'h1;
      MP_W16:  lane_en = 4'h3;
      default: lane_en = 4'hF;
    endcase
  end

  // Mask bit i covers data bits 8i+7:8i
  logic [31:0] lane_bits;
  genvar g;
  for (g = 0; g < `MP_LANES; g++)
  begin : g_lane
    assign lane_bits[8*g +: 8] = {8{lane_en[g] & cur_reg.be[g]}};
  end

  // Split the word address into column and row
  logic [4:0]  col_w;
  logic [23:0] col_mask;
  logic [10:0] col_addr;
  logic [12:0] row_addr;
  logic [21:0] row_pins;
  logic [21:0] col_pins;
  logic [21:0] pre_pins;
  always_comb
  begin
    col_w    = 5'(`MP_COL_MIN) + {3'h0, col_bits_sel};
    col_mask = (24'h1 << col_w) - 24'h1;
    col_addr = 11'(req.addr & col_mask);
    row_addr = 13'(req.addr >> col_w);
    // Row and bank share the pins, upper bits parked low
    row_pins = '0;
    row_pins[12:0] = row_addr;
    row_pins[`MP_SDR_BA_LSB +: 2] = req.bank;
    // Bit 10 is the precharge flag, so column bit 10 moves to bit 11
    col_pins = '0;
    col_pins[9:0] = col_addr[9:0];
    col_pins[11] = (col_w == 5'(`MP_COL_MAX)) ? col_addr[10] : 1'h0;
    col_pins[`MP_SDR_BA_LSB +: 2] = req.bank;
    pre_pins = '0;
    pre_pins[`MP_SDR_AP_BIT] = 1'h1;
  end

  // Column pins are formed at accept time and held for the command
  logic [21:0] col_hold_reg, col_hold_next;

  // Next-state and pin computation
  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    cur_next      = cur_reg;
    sdr_next      = sdr_reg;
    ios_next      = ios_reg;
    addr_next     = addr_reg;
    dout_next     = dout_reg;
    oe_next       = 4'h0;
    rv_next       = 1'h0;
    rd_next       = rd_reg;
    col_hold_next = col_hold_reg;
    // Command pins fall back to no-operation every cycle
    sdr_next.ras_n = 1'h1;
    sdr_next.cas_n = 1'h1;
    sdr_next.we_n  = 1'h1;
    case (state_reg)
      ST_IDLE:
      begin
        sdr_next = SDR_IDLE;
        ios_next = 3'h7;
        if (req_valid && rdy_reg)
        begin
          cur_next = req;
          if (req.io)
          begin
            // One select only; bank 3 also drives bank 2's select
            if (req.bank == 2'h0)
              ios_next = 3'h6;
            else if (req.bank == 2'h1)
              ios_next = 3'h5;
            else
              ios_next = 3'h3;
            addr_next = {8'h00, req.addr[`MP_IO_ADDR_W-1:0]};
            dout_next = req.wdata;
            oe_next   = req.write ? (lane_en & req.be) : 4'h0;
            cnt_next  = io_wait_cfg;
            state_next = ST_IO;
          end
          else
          begin
            // Closed page, so every access starts with an activate
            // Activate: only the chosen bank's select goes low
            sdr_next.cs_n  = req.bank[0] ? 2'h1 : 2'h2;
            sdr_next.ras_n = 1'h0;
            addr_next      = row_pins;
            col_hold_next  = col_pins;
            cnt_next       = 8'(TRCD - 1);
            state_next     = ST_RCD;
          end
        end
      end
      ST_RCD:
      begin
        // Row-to-column delay, counted down from TRCD-1
        if (cnt_reg != 8'h00)
          cnt_next = cnt_reg - 8'h01;
        else
        begin
          // Read or write command on the column phase
          sdr_next.cas_n = 1'h0;
          sdr_next.we_n  = ~cur_reg.write;
          sdr_next.dqm   = ~(lane_en & cur_reg.be);
          addr_next      = col_hold_reg;
          dout_next      = cur_reg.wdata;
          oe_next        = cur_reg.write ? (lane_en & cur_reg.be) : 4'h0;
          cnt_next = cur_reg.write ? 8'(TWR - 1) : 8'(CAS_LAT - 1);
          state_next = ST_CAS;
        end
      end
      ST_CAS:
      begin
        if (cnt_reg != 8'h00)
          cnt_next = cnt_reg - 8'h01;
        else
        begin
          if (!cur_reg.write)
          begin
            // Masked lanes were not driven, so read them as zero
            rd_next = ext_data_lane_in & lane_bits;
            rv_next = 1'h1;
          end
          // Precharge all banks, then wait out the recovery
          sdr_next.ras_n = 1'h0;
          sdr_next.we_n  = 1'h0;
          sdr_next.dqm   = 4'hF;
          addr_next      = pre_pins;
          cnt_next       = 8'(TRP - 1);
          state_next     = ST_RP;
        end
      end
      ST_RP:
      begin
        // Recovery done: drop the select before the gap cycle
        if (cnt_reg != 8'h00)
          cnt_next = cnt_reg - 8'h01;
        else
        begin
          if (cur_reg.write)
            rv_next = 1'h1;
          sdr_next.cs_n = 2'h3;
          state_next    = ST_IDLE;
        end
      end
      ST_IO:
      begin
        // Configured cycles first; the wait input only counts after them
        oe_next = cur_reg.write ? (lane_en & cur_reg.be) : 4'h0;
        if (cnt_reg != 8'h00)
          cnt_next = cnt_reg - 8'h01;
        else if (ext_wait_n)
        begin
          if (!cur_reg.write)
            rd_next = ext_data_lane_in & lane_bits;
          rv_next    = 1'h1;
          ios_next   = 3'h7;
          oe_next    = 4'h0;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        sdr_next   = SDR_IDLE;
        ios_next   = 3'h7;
        state_next = ST_IDLE;
      end
    endcase
    // A gap cycle after each access keeps selects from overlapping
    // Costs one cycle per access, buys a clean bus hand-over
    rdy_next = (state_next == ST_IDLE) && (state_reg == ST_IDLE) &&
               !(req_valid && rdy_reg);
  end

  // State and pin registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 8'h00;
      cur_reg      <= '0;
      sdr_reg      <= SDR_IDLE;
      ios_reg      <= 3'h7;
      addr_reg     <= 22'h000000;
      dout_reg     <= 32'h00000000;
      oe_reg       <= 4'h0;
      rdy_reg      <= 1'h0;
      rv_reg       <= 1'h0;
      rd_reg       <= 32'h00000000;
      col_hold_reg <= 22'h000000;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      cur_reg      <= cur_next;
      sdr_reg      <= sdr_next;
      ios_reg      <= ios_next;
      addr_reg     <= addr_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
      rdy_reg      <= rdy_next;
      rv_reg       <= rv_next;
      rd_reg       <= rd_next;
      col_hold_reg <= col_hold_next;
    end
  end

  // Ports straight from the registers
  assign req_ready           = rdy_reg;
  assign rsp_valid           = rv_reg;
  assign rsp_rdata           = rd_reg;
  assign ext_addr            = addr_reg;
  assign ext_data_lane_out   = dout_reg;
  assign ext_data_lane_oe    = oe_reg;
  assign sdram_bank_select_n = sdr_reg.cs_n;
  assign sdram_row_strobe_n  = sdr_reg.ras_n;
  assign sdram_col_strobe_n  = sdr_reg.cas_n;
  assign sdram_write_en_n    = sdr_reg.we_n;
  assign sdram_byte_mask     = sdr_reg.dqm;
  assign io_bank_select_n    = ios_reg;

endmodule : mport_mem_port

`default_nettype wire

/* File: tb/mport_mem_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mport_mem_port_sva
  import mport_pkg::*;
#(
  parameter int CAS_LAT = 2,
  parameter int TRCD    = 5,
  parameter int TRP     = 5,
  parameter int TWR     = 4
)
(
  input wire logic         clock,               // Clock
  input wire logic         rst_b,               // Reset, low
  input wire mport_width_t bus_width,           // Width
  input wire logic         req_valid,           // Offer
  input wire mport_req_t   req,                 // Request
  input wire logic         req_ready,           // Idle
  input wire logic         rsp_valid,           // Done
  input wire logic [21:0]  ext_addr,            // Address
  input wire logic [1:0]   sdram_bank_select_n, // SDRAM selects
  input wire logic         sdram_row_strobe_n,  // Row strobe
  input wire logic         sdram_col_strobe_n,  // Column strobe
  input wire logic         sdram_write_en_n,    // Write enable
  input wire logic [3:0]   sdram_byte_mask,     // Masks
  input wire logic [2:0]   io_bank_select_n,    // I/O selects
  input wire logic         ext_wait_n           // Wait
);
  localparam int CAS_AT = TRCD + 1;
  localparam int WR_END = TWR + TRP;
  logic       take;
  logic [3:0] lanes;
  logic [3:0] mask_reg;
  logic [1:0] sdr_reg;
  logic [2:0] io_reg;
  // Live lanes and accept strobe
  assign lanes = (bus_width == MP_W8) ? 4'h1 : (bus_width == MP_W16) ? 4'h3 : 4'hF;
  assign take  = req_valid && req_ready;
  // Expected pins noted at accept, since req moves on afterwards
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      mask_reg <= 4'hF;
      sdr_reg  <= 2'h3;
      io_reg   <= 3'h7;
    end
    else if (take)
    begin
      mask_reg <= ~(lanes & req.be);
      sdr_reg  <= req.bank[0] ? 2'h1 : 2'h2;
      io_reg   <= (req.bank == 2'h0) ? 3'h6 : (req.bank == 2'h1) ? 3'h5 : 3'h3;
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_ONE_SEL: assert property ($countones({~sdram_bank_select_n, ~io_bank_select_n}) <= 1)
    else $error("two bank selects low");
  AST_SDR_SEL: assert property (take && !req.io |=> sdram_bank_select_n == sdr_reg && !sdram_row_strobe_n)
    else $error("wrong SDRAM select at row phase");
  AST_IO_SEL: assert property (take && req.io |=> io_bank_select_n == io_reg && sdram_bank_select_n == 2'h3)
    else $error("wrong I/O select");
  AST_RD_SEQ: assert property (take && !req.io && !req.write |-> ##CAS_AT
    (!sdram_col_strobe_n && sdram_write_en_n) ##CAS_LAT (rsp_valid && !sdram_row_strobe_n))
    else $error("read command sequence wrong");
  AST_WR_SEQ: assert property (take && !req.io && req.write |-> ##CAS_AT
    (!sdram_col_strobe_n && !sdram_write_en_n) ##WR_END rsp_valid)
    else $error("write command sequence wrong");
  AST_MASK: assert property (!sdram_col_strobe_n |-> sdram_byte_mask == mask_reg)
    else $error("byte mask wrong at column phase");
  AST_IO_ADDR: assert property (io_bank_select_n != 3'h7 |-> ext_addr[21:14] == 8'h00)
    else $error("I/O address beyond bank window");
  AST_WAIT: assert property (io_bank_select_n != 3'h7 && !ext_wait_n |=> $stable(io_bank_select_n) && !rsp_valid)
    else $error("I/O access not stretched");
  AST_PULSE: assert property (rsp_valid |-> !req_ready ##1 !rsp_valid)
    else $error("done pulse too long or ready during it");
  AST_READY_IDLE: assert property (req_ready |-> sdram_bank_select_n == 2'h3 && io_bank_select_n == 3'h7)
    else $error("ready while a bank select is low");
endmodule : mport_mem_port_sva
bind mport_mem_port mport_mem_port_sva #(.CAS_LAT(CAS_LAT), .TRCD(TRCD), .TRP(TRP), .TWR(TWR))
  mport_mem_port_sva_i (.clock, .rst_b, .bus_width, .req_valid, .req, .req_ready, .rsp_valid, .ext_addr,
  .sdram_bank_select_n, .sdram_row_strobe_n, .sdram_col_strobe_n, .sdram_write_en_n, .sdram_byte_mask,
  .io_bank_select_n, .ext_wait_n);
`default_nettype wire

/* File: tb/mport_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mport_mem_model
(
  input  wire logic        clock,               // Clock
  input  wire logic [3:0]  stretch,             // Wait cycles
  input  wire logic [21:0] ext_addr,            // Address
  input  wire logic [31:0] ext_data_lane_out,   // Data from port
  input  wire logic [3:0]  ext_data_lane_oe,    // Port drive
  input  wire logic [1:0]  sdram_bank_select_n, // SDRAM selects
  input  wire logic        sdram_col_strobe_n,  // Column strobe
  input  wire logic        sdram_write_en_n,    // Write enable
  input  wire logic [3:0]  sdram_byte_mask,     // Masks
  input  wire logic [2:0]  io_bank_select_n,    // I/O selects
  output logic [31:0]      ext_data_lane_in,    // Data to port
  output logic             ext_wait_n           // Wait, low
);
  logic [31:0] sd_mem [32];
  logic [31:0] io_mem [16];
  logic [31:0] sd_q = 32'h0;
  logic [3:0]  sel_cnt = 4'h0;
  logic        io_on;
  logic [4:0]  sd_idx;
  initial
    for (int i = 0; i < 32; i++)
    begin
      sd_mem[i] = 32'h0;
      io_mem[i % 16] = 32'h0;
    end
  // Decode; unselected lanes toggle so a stale value never looks valid
  assign io_on            = io_bank_select_n != 3'h7;
  assign sd_idx           = {sdram_bank_select_n[0], ext_addr[3:0]};
  assign ext_wait_n       = !(io_on && sel_cnt < stretch);
  assign ext_data_lane_in = (io_on && ext_data_lane_oe == 4'h0) ? io_mem[ext_addr[3:0]] : sd_q;
  // Read data one cycle after column phase, write store per unmasked lane
  always @(posedge clock)
  begin
    sel_cnt <= io_on ? sel_cnt + 4'h1 : 4'h0;
    sd_q    <= ~sd_q;
    for (int i = 0; i < 4; i++)
    begin
      if (!sdram_col_strobe_n && sdram_write_en_n && !sdram_byte_mask[i])
        sd_q[8*i +: 8] <= sd_mem[sd_idx][8*i +: 8];
      if (!sdram_col_strobe_n && !sdram_write_en_n && !sdram_byte_mask[i])
        sd_mem[sd_idx][8*i +: 8] <= ext_data_lane_out[8*i +: 8];
      if (io_on && ext_data_lane_oe[i])
        io_mem[ext_addr[3:0]][8*i +: 8] <= ext_data_lane_out[8*i +: 8];
    end
  end
endmodule : mport_mem_model
`default_nettype wire

/* File: tb/mport_mem_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mport_mem_port_tb
  import mport_pkg::*;
;
  typedef struct packed {logic rd; logic [31:0] exp;} mport_note_t;
  logic clock, rst_b, req_valid, req_ready, rsp_valid, ext_wait_n, row_n, col_n, we_n;
  mport_width_t bus_width;
  mport_req_t   req;
  mport_note_t  notes [$];
  mport_note_t  got;
  logic [1:0]   col_bits_sel, sd_cs_n;
  logic [7:0]   io_wait_cfg;
  logic [3:0]   stretch, oe, mask;
  logic [2:0]   io_cs_n;
  logic [21:0]  addr;
  logic [31:0]  rdata, d_in, d_out, rnd;
  logic [31:0]  sref [32];
  logic [31:0]  iref [16];
  integer       seed = 52;
  int           err_total = 0;
  int           cmp_count = 0;
  mport_mem_port mport_mem_port_i (.clock, .rst_b, .bus_width, .col_bits_sel, .io_wait_cfg, .req_valid, .req,
    .req_ready, .rsp_valid, .rsp_rdata(rdata), .ext_addr(addr), .ext_data_lane_in(d_in), .ext_data_lane_out(d_out),
    .ext_data_lane_oe(oe), .sdram_bank_select_n(sd_cs_n), .sdram_row_strobe_n(row_n), .sdram_col_strobe_n(col_n),
    .sdram_write_en_n(we_n), .sdram_byte_mask(mask), .io_bank_select_n(io_cs_n), .ext_wait_n);
  mport_mem_model mport_mem_model_i (.clock, .stretch, .ext_addr(addr), .ext_data_lane_out(d_out),
    .ext_data_lane_oe(oe), .sdram_bank_select_n(sd_cs_n), .sdram_col_strobe_n(col_n), .sdram_write_en_n(we_n),
    .sdram_byte_mask(mask), .io_bank_select_n(io_cs_n), .ext_data_lane_in(d_in), .ext_wait_n);
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Bounded wait; clock edge first so valid never toggles twice in a step
  task automatic do_req(input logic wr, input logic io, input logic [1:0] bk, input logic [3:0] lo);
    mport_note_t n;
    logic [31:0] m;
    logic [3:0]  en;
    int          t;
    @(posedge clock);
    #1;
    rnd = $random(seed);
    req = '{write: wr, io: io, bank: bk, addr: {rnd[23:4], lo}, wdata: $random(seed), be: rnd[27:24]};
    en  = req.be & ((bus_width == MP_W8) ? 4'h1 : (bus_width == MP_W16) ? 4'h3 : 4'hF);
    m   = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
    n.rd  = !wr;
    n.exp = (io ? iref[lo] : sref[{bk[0], lo}]) & m;
    if (wr && io)
      iref[lo] = (iref[lo] & ~m) | (req.wdata & m);
    if (wr && !io)
      sref[{bk[0], lo}] = (sref[{bk[0], lo}] & ~m) | (req.wdata & m);
    req_valid = 1'b1;
    for (t = 0; t < 200 && req_ready !== 1'b1; t++)
    begin
      @(posedge clock);
      #1;
    end
    if (t == 200)
    begin
      err_total++;
      $display("timeout at %0t waiting for ready", $time);
      give_verdict();
    end
    @(posedge clock);
    notes.push_back(n);
    #1;
    req_valid = 1'b0;
  endtask : do_req
  task automatic drain();
    int t;
    for (t = 0; t < 100 && notes.size() != 0; t++)
      @(posedge clock);
    #1;
    if (t == 100)
    begin
      err_total++;
      $display("timeout at %0t waiting for answers", $time);
      give_verdict();
    end
  endtask : drain
  // Scoreboard: oldest note against each done pulse
  always @(posedge clock)
    if (rsp_valid === 1'b1)
    begin
      got = notes.size() ? notes.pop_front() : mport_note_t'{rd: 1'b1, exp: 32'hDEADBEEF};
      cmp_count++;
      if (got.rd && rdata !== got.exp)
      begin
        err_total++;
        $display("mismatch at %0t: got %h expected %h", $time, rdata, got.exp);
      end
    end
  // Per width: SDRAM banks then I/O banks, writes then read-back
  initial
  begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    bus_width = MP_W32;
    col_bits_sel = 2'h0;
    io_wait_cfg = 8'h00;
    stretch = 4'h0;
    for (int i = 0; i < 32; i++)
    begin
      sref[i] = 32'h0;
      iref[i % 16] = 32'h0;
    end
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    for (int w = 2; w >= 0; w--)
    begin
      bus_width = mport_width_t'(w);
      rnd = $random(seed);
      col_bits_sel = rnd[1:0];
      for (int k = 0; k < 8; k++)
        do_req(k < 4, 1'b0, 2'(k), 4'(k % 4));
      drain();
      io_wait_cfg = {6'h00, rnd[3:2]};
      stretch = 4'h1 + {2'h0, rnd[5:4]};
      for (int k = 0; k < 8; k++)
        do_req(k < 4, 1'b1, 2'(k), 4'(k % 4));
      drain();
      $display("test width %0d done", w);
    end
    give_verdict();
  end
endmodule : mport_mem_port_tb
`default_nettype wire
